// *** design/t0cc_defines.svh ***
// Register indices, field positions and encodings of the timer 0 block
`ifndef T0CC_DEFINES_SVH
`define T0CC_DEFINES_SVH
// Register indices; byte address is four times the index
`define T0CC_IDX_CTRL 12'h0E5
`define T0CC_IDX_COUNT 12'h0E6
`define T0CC_IDX_CAPT 12'h0E7
`define T0CC_IDX_STAT 12'h0E8
`define T0CC_IDX_IEN 12'h0E9
`define T0CC_IDX_ICLR 12'h0EA
// Control register fields
`define T0CC_CTRL_RESET 8'h00
`define T0CC_SEL_HI 7
`define T0CC_SEL_LO 5
`define T0CC_MODE_HI 4
`define T0CC_MODE_LO 3
`define T0CC_CLR_BIT 2
`define T0CC_MCIE_BIT 1
`define T0CC_OVIE_BIT 0
// Clock selection codes
`define T0CC_SEL_FXX1 3'h0
`define T0CC_SEL_D256 3'h1
`define T0CC_SEL_D64 3'h2
`define T0CC_SEL_D8 3'h3
`define T0CC_SEL_FXX 3'h4
`define T0CC_SEL_EXTF 3'h5
`define T0CC_SEL_EXTR 3'h6
`define T0CC_SEL_STOP 3'h7
// Capture mode codes
`define T0CC_MODE_CAPR 2'h1
`define T0CC_MODE_CAPF 2'h2
// Prescaler masks for each division
`define T0CC_MSK_D256 8'hFF
`define T0CC_MSK_D64 8'h3F
`define T0CC_MSK_D8 8'h07
// Interrupt status bits, their reset value and counter constants
`define T0CC_ST_CAPT 0
`define T0CC_ST_OVF 1
`define T0CC_ST_RESET 2'h0
`define T0CC_CNT_RESET 8'h00
`define T0CC_CNT_MAX 8'hFF
`define T0CC_CNT_ONE 8'h01
`endif

// *** design/t0cc_pkg.sv ***
// Types shared by the timer 0 control and capture block
package t0cc_pkg;
  typedef enum logic {BUS_IDLE, BUS_ACK} t0cc_bus_t;
  typedef logic [7:0] t0cc_byte_t;
endpackage

// *** design/t0cc_top.sv ***
// Timer 0 counter with clock select, capture, clear and Avalon-MM registers
`timescale 1ns/1ps
`include "t0cc_defines.svh"
module t0cc_top #(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk, // System clock, 20 MHz
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic [ADDR_W-1:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data, low byte used
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Low for one cycle to answer
  input wire logic timer0_external_clock_pin, // External count clock
  input wire logic capture_pin, // Capture input
  output logic irq // Level interrupt
);

  // Byte addresses of the registers
  localparam logic [ADDR_W-1:0] ADR_CTRL = ADDR_W'(`T0CC_IDX_CTRL << 2);
  localparam logic [ADDR_W-1:0] ADR_COUNT = ADDR_W'(`T0CC_IDX_COUNT << 2);
  localparam logic [ADDR_W-1:0] ADR_CAPT = ADDR_W'(`T0CC_IDX_CAPT << 2);
  localparam logic [ADDR_W-1:0] ADR_STAT = ADDR_W'(`T0CC_IDX_STAT << 2);
  localparam logic [ADDR_W-1:0] ADR_IEN = ADDR_W'(`T0CC_IDX_IEN << 2);
  localparam logic [ADDR_W-1:0] ADR_ICLR = ADDR_W'(`T0CC_IDX_ICLR << 2);

  // Each register except the pin synchronisers sits beside the next value that its process computes
  t0cc_pkg::t0cc_bus_t bus_state;
  t0cc_pkg::t0cc_bus_t next_bus_state;
  logic next_waitrequest;
  logic [31:0] next_readdata;
  t0cc_pkg::t0cc_byte_t ctrl;
  t0cc_pkg::t0cc_byte_t next_ctrl;
  t0cc_pkg::t0cc_byte_t count;
  t0cc_pkg::t0cc_byte_t next_count;
  t0cc_pkg::t0cc_byte_t capt;
  t0cc_pkg::t0cc_byte_t next_capt;
  t0cc_pkg::t0cc_byte_t presc;
  t0cc_pkg::t0cc_byte_t next_presc;
  logic [1:0] status;
  logic [1:0] next_status;
  logic [1:0] ien;
  logic [1:0] next_ien;
  logic next_irq;
  logic [2:0] ext_sync;
  logic [2:0] cap_sync;
  logic wr_take;
  logic wr_ctrl;
  logic wr_iclr;
  logic wr_ien;
  logic tick;
  logic ext_fall;
  logic ext_rise;
  logic cap_rise;
  logic cap_fall;
  logic cap_evt;
  logic ovf_evt;
  logic [2:0] sel;
  logic [1:0] mode;
  logic [1:0] set_mask;
  logic [1:0] gate;

  // Control fields; the clear bit is never stored, so it cannot repeat
  assign sel = ctrl[`T0CC_SEL_HI:`T0CC_SEL_LO];
  assign mode = ctrl[`T0CC_MODE_HI:`T0CC_MODE_LO];

  // Pin synchronisers; stage 0 is read only by stage 1
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ext_sync <= 3'h0;
      cap_sync <= 3'h0;
    end else if (ce) begin
      ext_sync <= {ext_sync[1:0], timer0_external_clock_pin};
      cap_sync <= {cap_sync[1:0], capture_pin};
    end
  end

  // Edges seen between stage 1 and stage 2, two cycles after the pin
  assign ext_fall = ext_sync[2] && !ext_sync[1];
  assign ext_rise = !ext_sync[2] && ext_sync[1];
  assign cap_rise = !cap_sync[2] && cap_sync[1];
  assign cap_fall = cap_sync[2] && !cap_sync[1];

  // A write lands only on the edge where waitrequest is sampled low
  assign wr_take = ce && avs_write && (bus_state == t0cc_pkg::BUS_ACK)
                   && avs_byteenable[0];
  assign wr_ctrl = wr_take && (avs_address == ADR_CTRL);
  assign wr_ien = wr_take && (avs_address == ADR_IEN);
  assign wr_iclr = wr_take && (avs_address == ADR_ICLR);

  // Count tick from the selected source
  always_comb begin
    tick = 1'b0;
    case (sel)
      `T0CC_SEL_FXX1: tick = 1'b1;
      `T0CC_SEL_FXX: tick = 1'b1;
      `T0CC_SEL_D256: tick = (presc & `T0CC_MSK_D256) == `T0CC_MSK_D256;
      `T0CC_SEL_D64: tick = (presc & `T0CC_MSK_D64) == `T0CC_MSK_D64;
      `T0CC_SEL_D8: tick = (presc & `T0CC_MSK_D8) == `T0CC_MSK_D8;
      `T0CC_SEL_EXTF: tick = ext_fall;
      `T0CC_SEL_EXTR: tick = ext_rise;
      default: tick = 1'b0;
    endcase
  end

  // Capture and overflow events; capture never stops the counter
  assign cap_evt = ((mode == `T0CC_MODE_CAPR) && cap_rise)
                   || ((mode == `T0CC_MODE_CAPF) && cap_fall);
  assign ovf_evt = tick && (count == `T0CC_CNT_MAX) && !wr_ctrl;
  assign set_mask = {ovf_evt, cap_evt};
  assign gate = {ctrl[`T0CC_OVIE_BIT], ctrl[`T0CC_MCIE_BIT]};

  // Next values of the timer state
  always_comb begin
    next_presc = presc + `T0CC_CNT_ONE;
    next_count = count;
    next_capt = capt;
    next_ctrl = ctrl;
    next_ien = ien;
    next_status = status;
    if (tick) begin
      next_count = count + `T0CC_CNT_ONE;
    end
    // Clear wins over a tick in the same cycle
    if (wr_ctrl) begin
      next_ctrl = avs_writedata[7:0];
      next_ctrl[`T0CC_CLR_BIT] = 1'b0;
      if (avs_writedata[`T0CC_CLR_BIT]) begin
        next_count = `T0CC_CNT_RESET;
      end
    end
    if (cap_evt) begin
      next_capt = count;
    end
    if (wr_ien) begin
      next_ien = avs_writedata[1:0];
    end
    // A new event beats a clear in the same cycle
    if (wr_iclr) begin
      next_status = status & ~avs_writedata[1:0];
    end
    next_status = next_status | set_mask;
    next_irq = |(next_status & next_ien & gate);
  end

  // Timer registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      presc <= `T0CC_CNT_RESET;
      count <= `T0CC_CNT_RESET;
      capt <= `T0CC_CNT_RESET;
      ctrl <= `T0CC_CTRL_RESET;
      ien <= `T0CC_ST_RESET;
      status <= `T0CC_ST_RESET;
      irq <= 1'b0;
    end else if (ce) begin
      presc <= next_presc;
      count <= next_count;
      capt <= next_capt;
      ctrl <= next_ctrl;
      ien <= next_ien;
      status <= next_status;
      irq <= next_irq;
    end
  end

  // Bus answer: one wait cycle, then waitrequest low for one cycle
  always_comb begin
    next_bus_state = t0cc_pkg::BUS_IDLE;
    next_readdata = avs_readdata;
    if ((bus_state == t0cc_pkg::BUS_IDLE) && (avs_read || avs_write)) begin
      next_bus_state = t0cc_pkg::BUS_ACK;
      next_readdata = 32'h0;
      // Unmapped or write-only addresses read as zero
      if (avs_address == ADR_CTRL) begin
        next_readdata[7:0] = ctrl;
      end else if (avs_address == ADR_COUNT) begin
        next_readdata[7:0] = count;
      end else if (avs_address == ADR_CAPT) begin
        next_readdata[7:0] = capt;
      end else if (avs_address == ADR_STAT) begin
        next_readdata[1:0] = status;
      end else if (avs_address == ADR_IEN) begin
        next_readdata[1:0] = ien;
      end
    end
    next_waitrequest = (next_bus_state != t0cc_pkg::BUS_ACK);
  end

  // Bus registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bus_state <= t0cc_pkg::BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else if (ce) begin
      bus_state <= next_bus_state;
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
    end
  end

  // Bus handshake steps
  sequence s_bus_req;
    ce && (avs_read || avs_write) && avs_waitrequest
      && (bus_state == t0cc_pkg::BUS_IDLE);
  endsequence
  sequence s_bus_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  a_bus_answer: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_bus_req ##1 ce |-> s_bus_ack)
    else $error("Bus request not answered in one cycle");

  a_fxx_count: assert property (@(posedge ref_clk) disable iff (!resetn)
    ce && (sel == `T0CC_SEL_FXX1 || sel == `T0CC_SEL_FXX) && !wr_ctrl
      |=> count == $past(count) + `T0CC_CNT_ONE)
    else $error("Counter did not step on the system clock");

  a_stop_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    (sel == `T0CC_SEL_STOP) && !wr_ctrl |=> $stable(count))
    else $error("Stopped counter moved");

  a_div8_rate: assert property (@(posedge ref_clk) disable iff (!resetn)
    ce && (sel == `T0CC_SEL_D8) && !wr_ctrl
      && ((presc & `T0CC_MSK_D8) != `T0CC_MSK_D8) |=> $stable(count))
    else $error("Divide by 8 counter stepped early");

  a_ext_fall: assert property (@(posedge ref_clk) disable iff (!resetn)
    ce && (sel == `T0CC_SEL_EXTF) && ext_fall && !wr_ctrl
      |=> count == $past(count) + `T0CC_CNT_ONE)
    else $error("Falling external edge not counted");

  a_ext_rise: assert property (@(posedge ref_clk) disable iff (!resetn)
    ce && (sel == `T0CC_SEL_EXTR) && ext_rise && !wr_ctrl
      |=> count == $past(count) + `T0CC_CNT_ONE)
    else $error("Rising external edge not counted");

  a_cap_rise: assert property (@(posedge ref_clk) disable iff (!resetn)
    ce && (mode == `T0CC_MODE_CAPR) && cap_rise
      |=> capt == $past(count) && status[`T0CC_ST_CAPT])
    else $error("Rising capture missed");

  a_cap_fall: assert property (@(posedge ref_clk) disable iff (!resetn)
    ce && (mode == `T0CC_MODE_CAPF) && cap_fall
      |=> capt == $past(count) && status[`T0CC_ST_CAPT])
    else $error("Falling capture missed");

  a_clear_count: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    wr_ctrl && avs_writedata[`T0CC_CLR_BIT] |=> count == `T0CC_CNT_RESET)
    else $error("Counter clear failed");

  a_clear_reads0: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    !ctrl[`T0CC_CLR_BIT])
    else $error("Clear bit read back as one");

  a_irq_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(irq) |-> |(status & ien & $past(gate)))
    else $error("Interrupt raised without an enabled cause");

  a_ovf_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
    ce && ovf_evt |=> status[`T0CC_ST_OVF] && count == `T0CC_CNT_RESET)
    else $error("Overflow did not wrap and flag");

  // Divided clocks hold the count between prescaler wraps
  a_div64_rate: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    ce && (sel == `T0CC_SEL_D64) && !wr_ctrl
      && ((presc & `T0CC_MSK_D64) != `T0CC_MSK_D64) |=> $stable(count))
    else $error("Divide by 64 counter stepped early");

  a_div256_rate: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    ce && (sel == `T0CC_SEL_D256) && !wr_ctrl
      && ((presc & `T0CC_MSK_D256) != `T0CC_MSK_D256) |=> $stable(count))
    else $error("Divide by 256 counter stepped early");

  // In falling-edge mode, only a falling external edge may move the counter
  a_ext_idle: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    ce && (sel == `T0CC_SEL_EXTF) && !ext_fall && !wr_ctrl
      |=> $stable(count))
    else $error("Counter moved without a falling external edge");

  // Outside the capture modes the latch keeps its value
  a_cap_idle: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    ce && (mode != `T0CC_MODE_CAPR) && (mode != `T0CC_MODE_CAPF)
      |=> $stable(capt))
    else $error("Capture latch changed outside a capture mode");

  // A control write with the clear bit low leaves an idle counter alone
  a_clear_keep: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    wr_ctrl && !avs_writedata[`T0CC_CLR_BIT] && !tick
      |=> $stable(count))
    else $error("Counter changed on a write without clear");

endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the timer 0 control and capture block
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic [7:0] v; int kind;} t0cc_note_t;
  localparam logic [11:0] A_CTRL = 12'h394;
  localparam logic [11:0] A_CNT = 12'h398;
  localparam logic [11:0] A_CAPT = 12'h39C;
  localparam logic [11:0] A_STAT = 12'h3A0;
  localparam logic [11:0] A_IEN = 12'h3A4;
  localparam logic [11:0] A_ICLR = 12'h3A8;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hF;
  logic ext_pin = 1'b0;
  logic cap_pin = 1'b0;
  logic ce = 1'b1;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic [31:0] seed = 32'hB35D1021;
  logic [7:0] prev = 8'h00;
  logic [7:0] np;
  int fail_count = 0;
  int cmp_count = 0;
  t0cc_note_t notes[$];
  t0cc_note_t note;
  logic [2:0] sels[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  int divs[6] = '{1, 256, 64, 8, 1, 1};
  logic [7:0] dexp[6] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h00};

  // Free-running system clock, 50 ns period
  always #25 ref_clk = ~ref_clk;

  t0cc_top uut (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .ce(ce),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .timer0_external_clock_pin(ext_pin),
    .capture_pin(cap_pin),
    .irq(irq)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic results();
    $display("mismatches=%0d comparisons=%0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic compare_data(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // Sampled mid-cycle where irq has settled, then back on a rising edge
  task automatic compare_irq(input logic exp);
    @(negedge ref_clk);
    compare_data({31'h0, irq}, {31'h0, exp});
    @(posedge ref_clk);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // One Avalon transfer; a read notes its expectation first
  // Kind 0 exact, 1 step from previous read, 2 reference only
  task automatic bus(input logic wr, input logic [11:0] a,
    input logic [7:0] d, input int kind = 0, input logic [3:0] be = 4'hF);
    int n;
    if (!wr) notes.push_back('{d, kind});
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      fail_count++;
      results();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Idle edge so the next request never lands in the release step
    @(posedge ref_clk);
  endtask

  // Pin pulses wider than the synchroniser delay
  task automatic pulses(input logic [7:0] n);
    repeat (n) begin
      ext_pin <= 1'b1;
      cyc(4);
      ext_pin <= 1'b0;
      cyc(4);
    end
    cyc(6);
  endtask

  // Read answers are matched to the oldest note at the ack edge
  always @(posedge ref_clk) begin
    if (avs_read && avs_waitrequest === 1'b0 && notes.size() > 0) begin
      note = notes.pop_front();
      if (note.kind == 1) begin
        compare_data({24'h0, avs_readdata[7:0] - prev}, {24'h0, note.v});
      end else if (note.kind == 0) begin
        compare_data(avs_readdata, {24'h0, note.v});
      end
      prev = avs_readdata[7:0];
    end
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    bus(0, A_CTRL, 8'h00);
    bus(1, A_CTRL, 8'hE4);
    bus(0, A_CTRL, 8'hE0);
    bus(0, A_CNT, 8'h00);
    bus(1, A_CNT, 8'h55);
    bus(1, A_CTRL, 8'h00, 0, 4'hE);
    bus(1, 12'h3FC, 8'hFF);
    bus(0, 12'h3FC, 8'h00);
    bus(0, A_CTRL, 8'hE0);
    bus(0, A_CNT, 8'h00);
    // Spacing of 4 divisions makes the step independent of prescaler phase
    for (int i = 0; i < 6; i++) begin
      bus(1, A_CTRL, {sels[i], 5'h00});
      bus(0, A_CNT, 8'h00, 2);
      cyc(4 * divs[i] - 3);
      bus(0, A_CNT, dexp[i], 1);
    end
    for (int m = 0; m < 2; m++) begin
      seed = xs(seed);
      np = {5'h0, seed[2:0]} + 8'h01;
      bus(1, A_CTRL, (m == 1) ? 8'hC4 : 8'hA4);
      pulses(np);
      bus(0, A_CNT, np);
    end
    bus(1, A_IEN, 8'h03);
    bus(1, A_CTRL, 8'hA4);
    pulses(8'h03);
    bus(1, A_CTRL, 8'hE8);
    cap_pin <= 1'b1;
    cyc(6);
    bus(0, A_CAPT, 8'h03);
    bus(0, A_STAT, 8'h01);
    compare_irq(1'b0);
    bus(1, A_CTRL, 8'hEA);
    cyc(3);
    compare_irq(1'b1);
    cap_pin <= 1'b0;
    cyc(6);
    bus(1, A_CTRL, 8'hA0);
    pulses(8'h02);
    bus(1, A_CTRL, 8'hF0);
    bus(1, A_ICLR, 8'h01);
    cap_pin <= 1'b1;
    cyc(6);
    bus(0, A_STAT, 8'h00);
    bus(0, A_CAPT, 8'h03);
    cap_pin <= 1'b0;
    cyc(6);
    bus(0, A_CAPT, 8'h05);
    bus(0, A_STAT, 8'h01);
    // Overflow with its gate closed, then opened, then cleared
    bus(1, A_ICLR, 8'h03);
    bus(1, A_CTRL, 8'h04);
    cyc(300);
    compare_irq(1'b0);
    bus(0, A_STAT, 8'h02);
    bus(1, A_CTRL, 8'h01);
    cyc(3);
    compare_irq(1'b1);
    bus(1, A_ICLR, 8'h02);
    cyc(3);
    compare_irq(1'b0);
    // A low clock enable freezes the running counter for its whole span
    bus(1, A_CTRL, 8'h04);
    bus(0, A_CNT, 8'h00, 2);
    ce <= 1'b0;
    cyc(50);
    ce <= 1'b1;
    bus(0, A_CNT, 8'h03, 1);
    bus(1, A_CTRL, 8'hE0);
    results();
  end
endmodule
